// file: verilog/two_way_buffer_store_control.sv
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module two_way_buffer_store_control (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Processor port
  input wire logic cpu_req_in,
  input wire logic cpu_store_in,
  input wire logic [bsc_pkg::ADDR_W-1:0] cpu_addr_in,
  input wire logic [bsc_pkg::DATA_W-1:0] cpu_wdata_in,
  output logic cpu_ready_out,
  output logic cpu_done_out,
  output logic [bsc_pkg::DATA_W-1:0] cpu_rdata_out,
  output logic cpu_from_buf_out,
  // Main storage port
  output logic ms_rd_req_out,
  output logic ms_wr_req_out,
  output logic [bsc_pkg::ADDR_W-1:0] ms_addr_out,
  output logic [bsc_pkg::DATA_W-1:0] ms_wdata_out,
  input wire logic ms_rd_valid_in,
  input wire logic [bsc_pkg::HB_W-1:0] ms_rd_data_in,
  input wire logic [bsc_pkg::HB_PAR_W-1:0] ms_rd_par_in,
  input wire logic ms_wr_ack_in,
  // Channel store watch
  input wire logic chan_store_in,
  input wire logic [bsc_pkg::ADDR_W-1:0] chan_addr_in,
  // Console and machine check
  input wire logic console_disable_in,
  output logic machine_check_out,
  // Register port
  input wire logic [bsc_pkg::REG_AW-1:0] reg_addr_in,
  input wire logic [bsc_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [bsc_pkg::DATA_W-1:0] reg_rdata_out
);
  // ****************************************
  // Decoding
  // ****************************************
  function automatic logic [bsc_pkg::IDX_W-1:0] f_idx(input logic [bsc_pkg::ADDR_W-1:0] a);
    return a[bsc_pkg::IDX_LSB +: bsc_pkg::IDX_W];
  endfunction : f_idx

  function automatic logic [bsc_pkg::TAG_W-1:0] f_tag(input logic [bsc_pkg::ADDR_W-1:0] a);
    return a[bsc_pkg::TAG_LSB +: bsc_pkg::TAG_W];
  endfunction : f_tag

  function automatic logic f_hb(input logic [bsc_pkg::ADDR_W-1:0] a);
    return a[bsc_pkg::HB_BIT];
  endfunction : f_hb

  // Even parity per byte
  function automatic logic [bsc_pkg::HB_PAR_W-1:0] f_bpar(input logic [bsc_pkg::HB_W-1:0] d);
    logic [bsc_pkg::HB_PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < bsc_pkg::HB_PAR_W; i++)
    begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction : f_bpar

  // ****************************************
  // State
  // ****************************************
  bsc_pkg::state_t state_q;
  bsc_pkg::state_t next_state;
  logic [bsc_pkg::TAG_W-1:0] tag_q [0:1][0:bsc_pkg::BLOCKS-1];
  logic [1:0] vld_q [0:1][0:bsc_pkg::BLOCKS-1];
  logic [bsc_pkg::BLOCKS-1:0] ok_q [0:1];
  logic [bsc_pkg::BLOCKS-1:0] tpar_q [0:1];
  logic [bsc_pkg::DATA_W+3:0] mem [0:bsc_pkg::MEM_WORDS-1];
  logic [bsc_pkg::ADDR_W-1:0] addr_q;
  logic [bsc_pkg::DATA_W-1:0] wdata_q;
  logic store_q;
  logic latch_q;
  logic fill_q;
  logic fway_q;
  logic kill_q;
  logic ctrl_dis_q;
  logic [7:0] ret_cnt_q;
  logic [7:0] last_ret_q;

  logic [bsc_pkg::IDX_W-1:0] idx;
  logic [bsc_pkg::TAG_W-1:0] tag;
  logic hb;
  logic dis;
  logic [1:0] tperr;
  logic [1:0] usable;
  logic [1:0] hitw;
  logic [1:0] av;
  logic hit_any;
  logic hit_way;
  logic [bsc_pkg::MEM_AW-1:0] rd_index;
  logic [bsc_pkg::DATA_W+3:0] rword;
  logic [bsc_pkg::HB_PAR_W-1:0] wpar;
  logic [bsc_pkg::HB_PAR_W-1:0] spar;
  logic derr;
  logic alloc_en;
  logic alloc_way;
  logic pbad;
  logic chan_hits_req;
  logic kill;
  logic fill_now;
  logic [1:0] ret;
  logic [bsc_pkg::DATA_W-1:0] ms_word;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  assign idx = f_idx(addr_q);
  assign tag = f_tag(addr_q);
  assign hb = f_hb(addr_q);
  assign dis = console_disable_in | ctrl_dis_q;

  // ****************************************
  // Lookup
  // ****************************************
  always_comb
  begin
    for (int w = 0; w < 2; w++)
    begin
      tperr[w] = ok_q[w][idx] && (tpar_q[w][idx] != ^tag_q[w][idx]);
      usable[w] = ok_q[w][idx] && !tperr[w] && !dis;
      hitw[w] = usable[w] && (tag_q[w][idx] == tag) && vld_q[w][idx][hb];
      av[w] = (vld_q[w][idx] == 2'b00);
    end
  end

  assign hit_any = |hitw;
  assign hit_way = hitw[1];
  assign rd_index = {hit_way, idx, hb, addr_q[bsc_pkg::WORD_LSB +: 2]};
  assign rword = mem[rd_index];
  assign wpar = f_bpar({96'h0, rword[bsc_pkg::DATA_W-1:0]});
  assign derr = hit_any && (rword[bsc_pkg::DATA_W +: 4] != wpar[3:0]);
  assign spar = f_bpar({96'h0, wdata_q});

  // Compartment choice for a miss
  always_comb
  begin
    alloc_en = usable[0] | usable[1];
    if (usable[0] && usable[1])
    begin
      alloc_way = (av[0] != av[1]) ? av[1] : latch_q;
    end
    else
    begin
      alloc_way = usable[1];
    end
  end

  assign pbad = ms_rd_par_in != f_bpar(ms_rd_data_in);
  assign chan_hits_req = chan_store_in && (f_idx(chan_addr_in) == idx) &&
                         (f_tag(chan_addr_in) == tag) && (f_hb(chan_addr_in) == hb);
  assign kill = kill_q | chan_hits_req;
  assign fill_now = (state_q == bsc_pkg::S_RD) && ms_rd_valid_in && fill_q;
  assign ms_word = ms_rd_data_in[32*addr_q[bsc_pkg::WORD_LSB +: 2] +: 32];

  always_comb
  begin
    for (int w = 0; w < 2; w++)
    begin
      ret[w] = ((state_q == bsc_pkg::S_LOOK) && (tperr[w] || (derr && (hit_way == w)))) ||
               (fill_now && pbad && (fway_q == w));
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    next_state = state_q;
    unique case (state_q)
      bsc_pkg::S_IDLE:
      begin
        if (cpu_req_in)
        begin
          next_state = bsc_pkg::S_LOOK;
        end
      end
      bsc_pkg::S_LOOK:
      begin
        if (store_q)
        begin
          next_state = bsc_pkg::S_WR;
        end
        else if (hit_any && !derr)
        begin
          next_state = bsc_pkg::S_IDLE;
        end
        else
        begin
          next_state = bsc_pkg::S_RD;
        end
      end
      bsc_pkg::S_RD:
      begin
        if (ms_rd_valid_in)
        begin
          next_state = bsc_pkg::S_IDLE;
        end
      end
      bsc_pkg::S_WR:
      begin
        if (ms_wr_ack_in)
        begin
          next_state = bsc_pkg::S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= bsc_pkg::S_IDLE;
      cpu_ready_out <= 1'b1;
      cpu_done_out <= 1'b0;
      cpu_rdata_out <= '0;
      cpu_from_buf_out <= 1'b0;
      ms_rd_req_out <= 1'b0;
      ms_wr_req_out <= 1'b0;
      ms_addr_out <= '0;
      ms_wdata_out <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      store_q <= 1'b0;
      fill_q <= 1'b0;
      fway_q <= 1'b0;
      kill_q <= 1'b0;
    end
    else
    begin
      state_q <= next_state;
      cpu_ready_out <= (next_state == bsc_pkg::S_IDLE);
      cpu_done_out <= 1'b0;
      cpu_from_buf_out <= 1'b0;
      ms_rd_req_out <= 1'b0;
      ms_wr_req_out <= 1'b0;
      unique case (state_q)
        bsc_pkg::S_IDLE:
        begin
          if (cpu_req_in)
          begin
            addr_q <= cpu_addr_in;
            wdata_q <= cpu_wdata_in;
            store_q <= cpu_store_in;
          end
        end
        bsc_pkg::S_LOOK:
        begin
          kill_q <= chan_hits_req;
          ms_addr_out <= addr_q;
          if (store_q)
          begin
            ms_wr_req_out <= 1'b1;
            ms_wdata_out <= wdata_q;
          end
          else if (hit_any && !derr)
          begin
            cpu_done_out <= 1'b1;
            cpu_from_buf_out <= 1'b1;
            cpu_rdata_out <= rword[bsc_pkg::DATA_W-1:0];
          end
          else
          begin
            ms_rd_req_out <= 1'b1;
            fill_q <= alloc_en && !derr;
            fway_q <= alloc_way;
          end
        end
        bsc_pkg::S_RD:
        begin
          kill_q <= kill;
          if (ms_rd_valid_in)
          begin
            cpu_done_out <= 1'b1;
            cpu_rdata_out <= ms_word;
          end
        end
        bsc_pkg::S_WR:
        begin
          if (ms_wr_ack_in)
          begin
            cpu_done_out <= 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Replacement latch
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      latch_q <= bsc_pkg::LATCH_RST;
    end
    else if ((state_q == bsc_pkg::S_LOOK) && !store_q && hit_any && !derr)
    begin
      latch_q <= ~hit_way;
    end
  end

  // ****************************************
  // Index array
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int w = 0; w < 2; w++)
      begin
        ok_q[w] <= {bsc_pkg::BLOCKS{bsc_pkg::OK_RST}};
        tpar_q[w] <= '0;
        for (int b = 0; b < bsc_pkg::BLOCKS; b++)
        begin
          vld_q[w][b] <= 2'b00;
          tag_q[w][b] <= '0;
        end
      end
    end
    else
    begin
      for (int w = 0; w < 2; w++)
      begin
        if (chan_store_in && (tag_q[w][f_idx(chan_addr_in)] == f_tag(chan_addr_in)))
        begin
          vld_q[w][f_idx(chan_addr_in)][f_hb(chan_addr_in)] <= 1'b0;
        end
      end
      if (fill_now && !pbad && !kill)
      begin
        tag_q[fway_q][idx] <= tag;
        tpar_q[fway_q][idx] <= ^tag;
        if (tag_q[fway_q][idx] == tag)
        begin
          vld_q[fway_q][idx][hb] <= 1'b1;
        end
        else
        begin
          vld_q[fway_q][idx] <= hb ? 2'b10 : 2'b01;
        end
      end
      for (int w = 0; w < 2; w++)
      begin
        if (ret[w])
        begin
          ok_q[w][idx] <= 1'b0;
          vld_q[w][idx] <= 2'b00;
        end
      end
    end
  end

  // ****************************************
  // Data array
  // ****************************************
  always_ff @(posedge core_clk_in)
  begin
    if (fill_now && !pbad && !kill)
    begin
      for (int i = 0; i < 4; i++)
      begin
        mem[{fway_q, idx, hb, i[1:0]}] <= {ms_rd_par_in[4*i +: 4], ms_rd_data_in[32*i +: 32]};
      end
    end
    else if ((state_q == bsc_pkg::S_LOOK) && store_q && hit_any)
    begin
      mem[rd_index] <= {spar[3:0], wdata_q};
    end
  end

  // ****************************************
  // Machine check and registers
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      machine_check_out <= 1'b0;
      ret_cnt_q <= bsc_pkg::CNT_RST;
      last_ret_q <= bsc_pkg::CNT_RST;
    end
    else
    begin
      machine_check_out <= |ret;
      if (|ret)
      begin
        ret_cnt_q <= ret_cnt_q + 8'h01;
        last_ret_q <= {ret[1] & ~ret[0], idx};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_dis_q <= bsc_pkg::CTRL_DIS_RST;
      reg_rdata_out <= '0;
    end
    else
    begin
      if (reg_wr_in && (reg_addr_in == bsc_pkg::REG_CTRL))
      begin
        ctrl_dis_q <= reg_wdata_in[bsc_pkg::CTRL_DIS_BIT];
      end
      reg_rdata_out <= '0;
      if (reg_rd_in)
      begin
        unique case (reg_addr_in)
          bsc_pkg::REG_CTRL: reg_rdata_out[bsc_pkg::CTRL_DIS_BIT] <= ctrl_dis_q;
          bsc_pkg::REG_STAT:
          begin
            reg_rdata_out[bsc_pkg::STAT_DIS_BIT] <= dis;
            reg_rdata_out[bsc_pkg::STAT_LATCH_BIT] <= latch_q;
            reg_rdata_out[bsc_pkg::STAT_CNT_LSB +: 8] <= ret_cnt_q;
          end
          bsc_pkg::REG_LAST: reg_rdata_out[7:0] <= last_ret_q;
          default: reg_rdata_out <= '0;
        endcase
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_fetch_hit;
    (state_q == bsc_pkg::S_LOOK) && !store_q && hit_any && !derr;
  endsequence
  sequence s_fetch_miss;
    (state_q == bsc_pkg::S_LOOK) && !store_q && !(hit_any && !derr);
  endsequence
  sequence s_buf_answer;
    cpu_done_out && cpu_from_buf_out && !ms_rd_req_out;
  endsequence

  property p_hit_serve;
    s_fetch_hit |=> s_buf_answer;
  endproperty
  a_hit_serve: assert property (p_hit_serve) else $error("hit not served from buffer");
  property p_miss_fetch;
    s_fetch_miss |=> ms_rd_req_out && !cpu_done_out ##1 !ms_rd_req_out;
  endproperty
  a_miss_fetch: assert property (p_miss_fetch) else $error("miss did not fetch");
  property p_latch_hit;
    s_fetch_hit |=> (latch_q != $past(hit_way));
  endproperty
  a_latch_hit: assert property (p_latch_hit) else $error("latch not flipped on hit");
  property p_latch_fill;
    s_fetch_miss ##1 (state_q == bsc_pkg::S_RD) [*2] |-> $stable(latch_q);
  endproperty
  a_latch_fill: assert property (p_latch_fill) else $error("latch moved on fill");
  property p_store;
    (state_q == bsc_pkg::S_LOOK) && store_q |=> $stable(latch_q) && ms_wr_req_out;
  endproperty
  a_store: assert property (p_store) else $error("store handling wrong");
  property p_store_data;
    (state_q == bsc_pkg::S_LOOK) && store_q && hit_any |=>
      mem[$past(rd_index)][bsc_pkg::DATA_W-1:0] == $past(wdata_q);
  endproperty
  a_store_data: assert property (p_store_data) else $error("store hit not in buffer");
  property p_retire_mc;
    (|ret) |=> machine_check_out;
  endproperty
  a_retire_mc: assert property (p_retire_mc) else $error("retire without machine check");
  property p_no_retired_hit;
    hit_any |-> ok_q[hit_way][idx] && !dis;
  endproperty
  a_no_retired_hit: assert property (p_no_retired_hit) else $error("hit on dead block");
  property p_fill_valid;
    fill_now && !pbad && !kill |=> vld_q[$past(fway_q)][idx][hb] && (tag_q[$past(fway_q)][idx] == tag);
  endproperty
  a_fill_valid: assert property (p_fill_valid) else $error("fill did not set valid");
  property p_alloc_one;
    (s_fetch_miss and ((usable == 2'b11) && (av[0] != av[1]) && !derr)) |=>
      fway_q == $past(av[1]);
  endproperty
  a_alloc_one: assert property (p_alloc_one) else $error("free compartment not chosen");
  property p_alloc_latch;
    (s_fetch_miss and ((usable == 2'b11) && (av[0] == av[1]) && !derr)) |=>
      fway_q == $past(latch_q);
  endproperty
  a_alloc_latch: assert property (p_alloc_latch) else $error("latch not used");
endmodule : two_way_buffer_store_control
`default_nettype wire

// file: verilog/bsc_pkg.sv
// Operation
// - Two compartments, upper and lower, 4K each
// - Index array: 128 positions, two entries
// - Entry holds row tag, two valids, health
// - Load writes address bits 12-20 as tag
// - Halfblock load sets its valid bit
// - Block maps to same position, 32 bytes
// - Allocate per block, fill per halfblock
// - Fetch hit points latch at other compartment
// - Fetch causing load leaves latch alone
// - Reset points latch at upper compartment
// - Both blocks free: latch picks compartment
// - Both blocks used: latch picks compartment
// - One block free: use that one
// - Parity check data, tags, entering and leaving
// - Failure clears health; fetches go to storage
// - Retiring a block raises machine check
// - Console or command disables whole buffer
// - Store miss updates main storage only
// - Store hit writes buffer and main storage
// - Valid hit answers from buffer, else fetch
// - Channel store clears matching valid bits
// - Row holds 128 blocks of two halfblocks
package bsc_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int HB_W = 128;
  localparam int HB_PAR_W = 16;
  localparam int TAG_W = 9;
  localparam int IDX_W = 7;
  localparam int BLOCKS = 128;
  localparam int MEM_WORDS = 2048;
  localparam int MEM_AW = 11;
  // Field positions, little-endian index of the 24-bit address
  localparam int TAG_LSB = 12;
  localparam int IDX_LSB = 5;
  localparam int HB_BIT = 4;
  localparam int WORD_LSB = 2;
  // Register port
  localparam int REG_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_LAST = 4'h8;
  localparam int CTRL_DIS_BIT = 0;
  localparam int STAT_DIS_BIT = 0;
  localparam int STAT_LATCH_BIT = 1;
  localparam int STAT_CNT_LSB = 8;
  // Reset values
  localparam logic CTRL_DIS_RST = 1'b0;
  localparam logic LATCH_RST = 1'b0;
  localparam logic OK_RST = 1'b1;
  localparam logic [7:0] CNT_RST = 8'h00;
  typedef enum logic [1:0] {S_IDLE, S_LOOK, S_RD, S_WR} state_t;
endpackage : bsc_pkg

// file: dv/storage_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************
// Main storage behind the buffer
// ************************************
module storage_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Requests from the buffer
  input wire logic rd_req_in,
  input wire logic wr_req_in,
  input wire logic [bsc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [bsc_pkg::DATA_W-1:0] wdata_in,
  // Test controls
  input wire logic [3:0] lat_in,
  input wire logic bad_par_in,
  // Answers
  output logic rd_valid_out,
  output logic [bsc_pkg::HB_W-1:0] rd_data_out,
  output logic [bsc_pkg::HB_PAR_W-1:0] rd_par_out,
  output logic wr_ack_out
);
  logic [31:0] mem [int];
  logic [3:0] rd_cnt;
  logic [3:0] wr_cnt;
  logic [23:0] rd_addr;
  logic [23:0] wr_addr;
  logic [31:0] wr_data;
  logic [127:0] line;

  function automatic logic [31:0] word_at(input logic [21:0] w);
    word_at = mem.exists(int'(w)) ? mem[int'(w)] : {w, 10'h2A5};
  endfunction : word_at

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_cnt <= 4'h0;
      wr_cnt <= 4'h0;
      rd_valid_out <= 1'b0;
      wr_ack_out <= 1'b0;
      rd_data_out <= 128'h0;
      rd_par_out <= 16'h0;
    end
    else
    begin
      rd_valid_out <= 1'b0;
      wr_ack_out <= 1'b0;
      // Released data lines wander
      rd_data_out <= ~rd_data_out;
      rd_par_out <= ~rd_par_out;
      if (rd_req_in)
      begin
        rd_cnt <= lat_in;
        rd_addr <= addr_in;
      end
      else if (rd_cnt != 4'h0)
      begin
        rd_cnt <= rd_cnt - 4'h1;
        if (rd_cnt == 4'h1)
        begin
          for (int i = 0; i < 4; i++)
            line[32*i +: 32] = word_at({rd_addr[23:4], 2'(i)});
          rd_valid_out <= 1'b1;
          rd_data_out <= line;
          for (int j = 0; j < 16; j++)
            rd_par_out[j] <= ^line[8*j +: 8];
          if (bad_par_in)
            rd_par_out[0] <= ~^line[7:0];
        end
      end
      if (wr_req_in)
      begin
        wr_cnt <= lat_in;
        wr_addr <= addr_in;
        wr_data <= wdata_in;
      end
      else if (wr_cnt != 4'h0)
      begin
        wr_cnt <= wr_cnt - 4'h1;
        if (wr_cnt == 4'h1)
        begin
          mem[int'(wr_addr[23:2])] = wr_data;
          wr_ack_out <= 1'b1;
        end
      end
    end
  end
endmodule : storage_model
`default_nettype wire

// file: dv/two_way_buffer_store_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module two_way_buffer_store_control_test;
  localparam logic [23:0] ADR_A = 24'h019000;
  localparam logic [23:0] ADR_B = 24'h01B000;
  localparam logic [23:0] ADR_C = 24'h01C000;
  localparam logic [23:0] ADR_E = 24'h01E040;
  logic clk, rst_n, cpu_req, cpu_store, ready, done, from_buf;
  logic [23:0] cpu_addr, ms_addr, chan_addr, wr_addr_seen;
  logic [31:0] cpu_wdata, rdata, ms_wdata, reg_wdata, reg_rdata, wr_data_seen, rv;
  logic ms_rd_req, ms_wr_req, ms_rd_valid, ms_wr_ack, chan_store, console_dis, mcheck;
  logic [127:0] ms_rd_data;
  logic [15:0] ms_rd_par;
  logic [3:0] reg_addr, lat;
  logic reg_wr, reg_rd, bad_par;
  int n_errors, compares, n_mc, n_cycles;

  two_way_buffer_store_control u_dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .cpu_req_in(cpu_req), .cpu_store_in(cpu_store), .cpu_addr_in(cpu_addr),
    .cpu_wdata_in(cpu_wdata), .cpu_ready_out(ready), .cpu_done_out(done),
    .cpu_rdata_out(rdata), .cpu_from_buf_out(from_buf), .ms_rd_req_out(ms_rd_req),
    .ms_wr_req_out(ms_wr_req), .ms_addr_out(ms_addr), .ms_wdata_out(ms_wdata),
    .ms_rd_valid_in(ms_rd_valid), .ms_rd_data_in(ms_rd_data), .ms_rd_par_in(ms_rd_par),
    .ms_wr_ack_in(ms_wr_ack), .chan_store_in(chan_store), .chan_addr_in(chan_addr),
    .console_disable_in(console_dis), .machine_check_out(mcheck), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata));

  storage_model u_mem (.clk_in(clk), .rst_n_in(rst_n), .rd_req_in(ms_rd_req),
    .wr_req_in(ms_wr_req), .addr_in(ms_addr), .wdata_in(ms_wdata), .lat_in(lat),
    .bad_par_in(bad_par), .rd_valid_out(ms_rd_valid), .rd_data_out(ms_rd_data),
    .rd_par_out(ms_rd_par), .wr_ack_out(ms_wr_ack));

  always #2 clk = ~clk;

  // ************************************
  // Checking and access tasks
  // ************************************
  task automatic finish_test;
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  function automatic logic [31:0] pat(input logic [23:0] a);
    pat = {a[23:2], 10'h2A5};
  endfunction : pat

  always @(posedge clk)
  begin
    if (ms_wr_req)
    begin
      wr_addr_seen <= ms_addr;
      wr_data_seen <= ms_wdata;
    end
    if (mcheck)
      n_mc++;
    n_cycles++;
    if (n_cycles == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end

  task automatic access(input logic st, input logic [23:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_store <= st;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_req <= 1'b0;
    for (k = 0; k < 100 && done !== 1'b1; k++)
      @(posedge clk);
    chk_bit("cpu_done_out", 1'b1, done);
    chk_bit("cpu_ready_out", 1'b1, ready);
  endtask : access

  task automatic fetch(input logic [23:0] a, input logic [31:0] exp, input logic hit);
    access(1'b0, a, 32'h0);
    chk_word("cpu_rdata_out", exp, rdata);
    chk_bit("cpu_from_buf_out", hit, from_buf);
  endtask : fetch

  task automatic store(input logic [23:0] a, input logic [31:0] d);
    access(1'b1, a, d);
    chk_word("ms_addr_out", {8'h00, a}, {8'h00, wr_addr_seen});
    chk_word("ms_wdata_out", d, wr_data_seen);
  endtask : store

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : reg_read

  task automatic chk_latch(input logic exp);
    reg_read(bsc_pkg::REG_STAT, rv);
    chk_bit("latch", exp, rv[bsc_pkg::STAT_LATCH_BIT]);
  endtask : chk_latch

  // ************************************
  // Test sequence
  // ************************************
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {cpu_req, cpu_store, reg_wr, reg_rd, chan_store, console_dis, bad_par} = 7'h00;
    cpu_addr = 24'h0;
    chan_addr = 24'h0;
    cpu_wdata = 32'h0;
    reg_wdata = 32'h0;
    reg_addr = 4'h0;
    lat = 4'h1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk_bit("cpu_ready_out", 1'b1, ready);
    reg_read(bsc_pkg::REG_CTRL, rv);
    chk_word("ctrl", 32'h0, rv);
    reg_read(bsc_pkg::REG_STAT, rv);
    chk_word("stat", 32'h0, rv);
    reg_read(bsc_pkg::REG_LAST, rv);
    chk_word("last", 32'h0, rv);
    fetch(ADR_A, pat(ADR_A), 1'b0);
    chk_latch(1'b0);
    fetch(ADR_A + 24'h4, pat(ADR_A + 24'h4), 1'b1);
    chk_latch(1'b1);
    lat <= 4'h7;
    fetch(ADR_B, pat(ADR_B), 1'b0);
    chk_latch(1'b1);
    fetch(ADR_B + 24'h4, pat(ADR_B + 24'h4), 1'b1);
    chk_latch(1'b0);
    fetch(ADR_A + 24'h8, pat(ADR_A + 24'h8), 1'b1);
    store(ADR_B + 24'h4, 32'hCAFE0001);
    chk_latch(1'b1);
    fetch(ADR_B + 24'h4, 32'hCAFE0001, 1'b1);
    store(ADR_C, 32'h0BAD0002);
    chk_latch(1'b0);
    fetch(ADR_A, pat(ADR_A), 1'b1);
    fetch(ADR_B, pat(ADR_B), 1'b1);
    fetch(ADR_C, 32'h0BAD0002, 1'b0);
    chk_latch(1'b0);
    fetch(ADR_B, pat(ADR_B), 1'b1);
    fetch(ADR_A, pat(ADR_A), 1'b0);
    fetch(ADR_B, pat(ADR_B), 1'b1);
    lat <= 4'h1;
    @(posedge clk);
    chan_store <= 1'b1;
    chan_addr <= ADR_A;
    @(posedge clk);
    chan_store <= 1'b0;
    fetch(ADR_A + 24'h4, pat(ADR_A + 24'h4), 1'b0);
    fetch(ADR_A + 24'h4, pat(ADR_A + 24'h4), 1'b1);
    fetch(ADR_A + 24'h10, pat(ADR_A + 24'h10), 1'b0);
    fetch(ADR_A + 24'h14, pat(ADR_A + 24'h14), 1'b1);
    reg_write(bsc_pkg::REG_CTRL, 32'h1);
    reg_read(bsc_pkg::REG_STAT, rv);
    chk_bit("stat disable", 1'b1, rv[bsc_pkg::STAT_DIS_BIT]);
    fetch(ADR_A + 24'h14, pat(ADR_A + 24'h14), 1'b0);
    fetch(ADR_A + 24'h14, pat(ADR_A + 24'h14), 1'b0);
    reg_read(bsc_pkg::REG_CTRL, rv);
    chk_word("ctrl", 32'h1, rv);
    reg_write(bsc_pkg::REG_CTRL, 32'h0);
    console_dis <= 1'b1;
    fetch(ADR_A + 24'h14, pat(ADR_A + 24'h14), 1'b0);
    console_dis <= 1'b0;
    fetch(ADR_A + 24'h14, pat(ADR_A + 24'h14), 1'b1);
    bad_par <= 1'b1;
    fetch(ADR_E, pat(ADR_E), 1'b0);
    fetch(ADR_E, pat(ADR_E), 1'b0);
    bad_par <= 1'b0;
    repeat (2) @(posedge clk);
    chk_word("machine checks", 32'h2, 32'(n_mc));
    fetch(ADR_E + 24'h4, pat(ADR_E + 24'h4), 1'b0);
    fetch(ADR_E + 24'h4, pat(ADR_E + 24'h4), 1'b0);
    reg_write(bsc_pkg::REG_STAT, 32'h0);
    reg_read(bsc_pkg::REG_STAT, rv);
    chk_word("retire count", 32'h2, {24'h0, rv[15:8]});
    reg_read(bsc_pkg::REG_LAST, rv);
    chk_word("retired block", 32'h82, {24'h0, rv[7:0]});
    reg_write(4'hC, 32'hFFFFFFFF);
    reg_read(4'hC, rv);
    chk_word("unmapped", 32'h0, rv);
    reg_read(bsc_pkg::REG_CTRL, rv);
    chk_word("ctrl", 32'h0, rv);
    finish_test();
  end
endmodule : two_way_buffer_store_control_test
`default_nettype wire
